/* rtl/pirf_pkg.sv */
// Package of offsets, field positions and reset values for the flag register
`default_nettype none
package pirf_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_BANK_SEL     = 8'h0F;
	localparam logic [7:0] IDX_FLAGS        = 8'h16;
	localparam logic [7:0] IDX_TIMER_CTRL   = 8'h20;
	localparam logic [7:0] IDX_T1_PERIOD    = 8'h21;
	localparam logic [7:0] IDX_T2_PERIOD    = 8'h22;
	localparam logic [7:0] IDX_T3_PERIOD    = 8'h23;
	localparam logic [7:0] IDX_PORT_B_PINS_SNAP   = 8'h24;
	// Bank that exposes the flag register
	localparam logic [3:0] FLAGS_BANK       = 4'h1;
	// Reset values
	localparam logic [7:0] FLAGS_RESET      = 8'h02;
	localparam logic [3:0] BANK_RESET       = 4'h0;
	localparam logic [7:0] CTRL_RESET       = 8'h00;
	localparam logic [7:0] T1_PERIOD_RESET  = 8'hFF;
	localparam logic [7:0] T2_PERIOD_RESET  = 8'hFF;
	localparam logic [15:0] T3_PERIOD_RESET = 16'hFFFF;
	// Flag bit positions
	localparam int BIT_PORT_B_PINS  = 7;
	localparam int BIT_T3     = 6;
	localparam int BIT_T2     = 5;
	localparam int BIT_T1     = 4;
	localparam int BIT_CAP2   = 3;
	localparam int BIT_CAP1   = 2;
	localparam int BIT_TX     = 1;
	localparam int BIT_RX     = 0;
	// Timer control field positions
	localparam int CTRL_WIDE    = 0;
	localparam int CTRL_CAP1SEL = 1;
	localparam int CTRL_RUN1    = 2;
	localparam int CTRL_RUN2    = 3;
	localparam int CTRL_RUN3    = 4;
	// AHB-Lite codes
	localparam logic       HRESP_OKAY = 1'b0;
	// Bus slave states
	typedef enum logic [1:0] {
		BUS_IDLE      = 2'b00,
		BUS_WRITE     = 2'b01,
		BUS_READ_WAIT = 2'b10,
		BUS_READ_DONE = 2'b11
	} pirf_bus_t;
endpackage : pirf_pkg
`default_nettype wire

/* rtl/pirf_pin_events.sv */
// Port-B change detector and capture pin edge detectors
`default_nettype none
module pirf_pin_events #(
	parameter int PORT_W = 8
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic [PORT_W-1:0] port_b_pins,
	input  wire logic              snapshot_load,
	input  wire logic              capture1_pin,
	input  wire logic              capture2_pin,
	output logic [PORT_W-1:0]      port_b_latched,
	output logic                   port_b_mismatch,
	output logic                   cap1_event,
	output logic                   cap2_event
);
	import pirf_pkg::*;

	logic              primed_reg;
	logic [PORT_W-1:0] latch_reg;
	logic              cap1_prev_reg;
	logic              cap2_prev_reg;
	logic              mismatch_reg;
	logic              cap1_ev_reg;
	logic              cap2_ev_reg;

	// Rising edges count as capture events; first cycle only primes history
	wire cap1_rise = primed_reg & capture1_pin & ~cap1_prev_reg;
	wire cap2_rise = primed_reg & capture2_pin & ~cap2_prev_reg;
	wire differs   = primed_reg & (port_b_pins != latch_reg);

	// Latch reloads at the first cycle after reset, so a strap level is no
	// spurious change, and again whenever software takes a snapshot
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			primed_reg    <= 1'b0;
			latch_reg     <= '0;
			cap1_prev_reg <= 1'b0;
			cap2_prev_reg <= 1'b0;
			mismatch_reg  <= 1'b0;
			cap1_ev_reg   <= 1'b0;
			cap2_ev_reg   <= 1'b0;
		end else begin
			primed_reg    <= 1'b1;
			if (!primed_reg || snapshot_load) begin
				latch_reg <= port_b_pins;
			end
			cap1_prev_reg <= capture1_pin;
			cap2_prev_reg <= capture2_pin;
			mismatch_reg  <= differs;
			cap1_ev_reg   <= cap1_rise;
			cap2_ev_reg   <= cap2_rise;
		end
	end

	assign port_b_latched  = latch_reg;
	assign port_b_mismatch = mismatch_reg;
	assign cap1_event      = cap1_ev_reg;
	assign cap2_event      = cap2_ev_reg;
endmodule : pirf_pin_events
`default_nettype wire

/* rtl/pirf_timers.sv */
// Three period timers producing one-cycle wrap events
`default_nettype none
module pirf_timers #(
	parameter int TMR_W = 8
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               run1,
	input  wire logic               run2,
	input  wire logic               run3,
	input  wire logic               wide_mode,
	input  wire logic               capture1_select,
	input  wire logic [TMR_W-1:0]   period1,
	input  wire logic [TMR_W-1:0]   period2,
	input  wire logic [2*TMR_W-1:0] period3,
	output logic                    t1_wrap,
	output logic                    t2_wrap,
	output logic                    t3_wrap
);
	import pirf_pkg::*;

	logic [TMR_W-1:0]   t1_reg;
	logic [TMR_W-1:0]   t1_next;
	logic [TMR_W-1:0]   t2_reg;
	logic [TMR_W-1:0]   t2_next;
	logic [2*TMR_W-1:0] t3_reg;
	logic [2*TMR_W-1:0] t3_next;
	logic               ev1;
	logic               ev2;
	logic               ev3;
	logic               ev1_reg;
	logic               ev2_reg;
	logic               ev3_reg;

	// First timer is the high half of the pair in wide mode
	wire [2*TMR_W-1:0] pair_cnt   = {t1_reg, t2_reg};
	wire [2*TMR_W-1:0] pair_per   = {period1, period2};
	wire [2*TMR_W-1:0] pair_inc   = pair_cnt + 1'b1;
	wire               pair_match = pair_cnt == pair_per;
	wire               t1_match   = t1_reg == period1;
	wire               t2_match   = t2_reg == period2;
	wire               t3_top     = t3_reg == {2*TMR_W{1'b1}};
	wire               t3_match   = capture1_select ? t3_top
	                                                : (t3_reg == period3);

	// Count and wrap; a match wraps the count to zero and fires the event
	always_comb begin
		t1_next = t1_reg;
		t2_next = t2_reg;
		t3_next = t3_reg;
		ev1     = 1'b0;
		ev2     = 1'b0;
		ev3     = 1'b0;
		if (wide_mode) begin
			if (run1 && pair_match) begin
				t1_next = '0;
				t2_next = '0;
				ev1     = 1'b1;
			end else if (run1) begin
				t1_next = pair_inc[2*TMR_W-1:TMR_W];
				t2_next = pair_inc[TMR_W-1:0];
			end
		end else begin
			if (run1 && t1_match) begin
				t1_next = '0;
				ev1     = 1'b1;
			end else if (run1) begin
				t1_next = t1_reg + 1'b1;
			end
			if (run2 && t2_match) begin
				t2_next = '0;
				ev2     = 1'b1;
			end else if (run2) begin
				t2_next = t2_reg + 1'b1;
			end
		end
		if (run3 && t3_match) begin
			t3_next = '0;
			ev3     = 1'b1;
		end else if (run3) begin
			t3_next = t3_reg + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			t1_reg  <= '0;
			t2_reg  <= '0;
			t3_reg  <= '0;
			ev1_reg <= 1'b0;
			ev2_reg <= 1'b0;
			ev3_reg <= 1'b0;
		end else begin
			t1_reg  <= t1_next;
			t2_reg  <= t2_next;
			t3_reg  <= t3_next;
			ev1_reg <= ev1;
			ev2_reg <= ev2;
			ev3_reg <= ev3;
		end
	end

	assign t1_wrap = ev1_reg;
	assign t2_wrap = ev2_reg;
	assign t3_wrap = ev3_reg;
endmodule : pirf_timers
`default_nettype wire

/* rtl/pirf_flag_register.sv */
// Peripheral interrupt flag register with AHB-Lite register slave
`default_nettype none
module pirf_flag_register #(
	parameter int ADDR_W = 32,
	parameter int PORT_W = 8,
	parameter int TMR_W  = 8
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic [31:0]            hrdata,
	output logic                   hresp,
	input  wire logic [PORT_W-1:0] port_b_pins,
	input  wire logic              capture1_pin,
	input  wire logic              capture2_pin,
	input  wire logic              serial_tx_empty,
	input  wire logic              serial_rx_full,
	output logic [7:0]             peripheral_irq_flags
);
	import pirf_pkg::*;

	// Word index decode shared by every register
	function automatic logic reg_hit(input logic [ADDR_W-3:0] word,
	                                 input logic [7:0] idx);
		reg_hit = (word == {{(ADDR_W-10){1'b0}}, idx});
	endfunction : reg_hit

	pirf_bus_t           bus_reg;
	pirf_bus_t           bus_next;
	logic [ADDR_W-3:0]   word_reg;
	logic [31:0]         hrdata_reg;
	logic [3:0]          bank_reg;
	logic [7:0]          ctrl_reg;
	logic [7:0]          t1_period_reg;
	logic [7:0]          t2_period_reg;
	logic [15:0]         t3_period_reg;
	logic [7:2]          flags_rw_reg;
	logic [7:2]          flags_rw_next;
	logic                tx_empty_reg;
	logic                rx_full_reg;
	logic [31:0]         read_mux;
	logic [PORT_W-1:0]   port_b_latched;
	logic                port_b_mismatch;
	logic                cap1_event;
	logic                cap2_event;
	logic                t1_wrap;
	logic                t2_wrap;
	logic                t3_wrap;

	// Address phase accepted on a NONSEQ or SEQ transfer to this slave
	wire accept   = hsel & hready & htrans[1];
	wire wr_phase = bus_reg == BUS_WRITE;
	wire rd_latch = bus_reg == BUS_READ_WAIT;

	// Register selects; the flag slot is banked, everything else is not
	wire bank_ok     = bank_reg == FLAGS_BANK;
	wire hit_bank    = reg_hit(word_reg, IDX_BANK_SEL);
	wire hit_flags   = reg_hit(word_reg, IDX_FLAGS) & bank_ok;
	wire hit_ctrl    = reg_hit(word_reg, IDX_TIMER_CTRL);
	wire hit_t1p     = reg_hit(word_reg, IDX_T1_PERIOD);
	wire hit_t2p     = reg_hit(word_reg, IDX_T2_PERIOD);
	wire hit_t3p     = reg_hit(word_reg, IDX_T3_PERIOD);
	wire hit_snap    = reg_hit(word_reg, IDX_PORT_B_PINS_SNAP);
	wire snapshot_ld = rd_latch & hit_snap;

	// Hardware set terms; no enable or global disable gates them
	wire [7:2] hw_set = {port_b_mismatch,
	                     t3_wrap,
	                     t1_wrap & ctrl_reg[CTRL_WIDE] ? 1'b0 : t2_wrap,
	                     t1_wrap,
	                     cap2_event,
	                     cap1_event};

	// Software value wins over the stored one, a hardware set wins over both
	assign flags_rw_next = hw_set |
	                       ((wr_phase & hit_flags) ? hwdata[7:2]
	                                               : flags_rw_reg);

	// Bus state: writes complete at once, reads take one wait state so the
	// returned data reflects any write of the previous transfer
	always_comb begin
		case (bus_reg)
			BUS_READ_WAIT: bus_next = BUS_READ_DONE;
			BUS_IDLE,
			BUS_WRITE,
			BUS_READ_DONE: begin
				if (accept && hwrite) begin
					bus_next = BUS_WRITE;
				end else if (accept) begin
					bus_next = BUS_READ_WAIT;
				end else begin
					bus_next = BUS_IDLE;
				end
			end
			default: bus_next = BUS_IDLE;
		endcase
	end

	// Read selection; unmapped or wrong-bank reads return zero
	always_comb begin
		read_mux = 32'h0000_0000;
		if (hit_flags) begin
			read_mux[7:0] = peripheral_irq_flags;
		end else if (hit_bank) begin
			read_mux[3:0] = bank_reg;
		end else if (hit_ctrl) begin
			read_mux[7:0] = ctrl_reg;
		end else if (hit_t1p) begin
			read_mux[7:0] = t1_period_reg;
		end else if (hit_t2p) begin
			read_mux[7:0] = t2_period_reg;
		end else if (hit_t3p) begin
			read_mux[15:0] = t3_period_reg;
		end else if (hit_snap) begin
			read_mux[PORT_W-1:0] = port_b_pins;
		end
	end

	// Bus sequencing and read data capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_reg    <= BUS_IDLE;
			word_reg   <= '0;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			bus_reg <= bus_next;
			if (accept && bus_reg != BUS_READ_WAIT) begin
				word_reg <= haddr[ADDR_W-1:2];
			end
			if (rd_latch) begin
				hrdata_reg <= read_mux;
			end
		end
	end

	// Software registers written in the data phase of a write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bank_reg      <= BANK_RESET;
			ctrl_reg      <= CTRL_RESET;
			t1_period_reg <= T1_PERIOD_RESET;
			t2_period_reg <= T2_PERIOD_RESET;
			t3_period_reg <= T3_PERIOD_RESET;
		end else if (wr_phase) begin
			if (hit_bank) begin
				bank_reg <= hwdata[3:0];
			end
			if (hit_ctrl) begin
				ctrl_reg <= {3'h0, hwdata[4:0]};
			end
			if (hit_t1p) begin
				t1_period_reg <= hwdata[7:0];
			end
			if (hit_t2p) begin
				t2_period_reg <= hwdata[7:0];
			end
			if (hit_t3p) begin
				t3_period_reg <= hwdata[15:0];
			end
		end
	end

	// Flag storage; the two serial bits are sampled status, never written
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_rw_reg <= FLAGS_RESET[7:2];
			tx_empty_reg <= FLAGS_RESET[BIT_TX];
			rx_full_reg  <= FLAGS_RESET[BIT_RX];
		end else begin
			flags_rw_reg <= flags_rw_next;
			tx_empty_reg <= serial_tx_empty;
			rx_full_reg  <= serial_rx_full;
		end
	end

	// Port-B change and capture pin events
	pirf_pin_events #(
		.PORT_W (PORT_W)
	) u_pins (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.port_b_pins     (port_b_pins),
		.snapshot_load   (snapshot_ld),
		.capture1_pin    (capture1_pin),
		.capture2_pin    (capture2_pin),
		.port_b_latched  (port_b_latched),
		.port_b_mismatch (port_b_mismatch),
		.cap1_event      (cap1_event),
		.cap2_event      (cap2_event)
	);

	// Timers steered by the control and period registers
	pirf_timers #(
		.TMR_W (TMR_W)
	) u_timers (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.run1            (ctrl_reg[CTRL_RUN1]),
		.run2            (ctrl_reg[CTRL_RUN2]),
		.run3            (ctrl_reg[CTRL_RUN3]),
		.wide_mode       (ctrl_reg[CTRL_WIDE]),
		.capture1_select (ctrl_reg[CTRL_CAP1SEL]),
		.period1         (t1_period_reg[TMR_W-1:0]),
		.period2         (t2_period_reg[TMR_W-1:0]),
		.period3         (t3_period_reg[2*TMR_W-1:0]),
		.t1_wrap         (t1_wrap),
		.t2_wrap         (t2_wrap),
		.t3_wrap         (t3_wrap)
	);

	// Outputs; slave never errors, stalls only during a read's first cycle
	assign peripheral_irq_flags = {flags_rw_reg, tx_empty_reg, rx_full_reg};
	assign hreadyout = bus_reg != BUS_READ_WAIT;
	assign hrdata    = hrdata_reg;
	assign hresp     = HRESP_OKAY;
endmodule : pirf_flag_register
`default_nettype wire

/* verification/pirf_periph_model.sv */
// Peripheral-side model: port-B pins, capture pins and serial status levels
`default_nettype none
module pirf_periph_model (
	input  wire logic hclk,
	output logic [7:0] port_b_pins,
	output logic       capture1_pin,
	output logic       capture2_pin,
	output logic       serial_tx_empty,
	output logic       serial_rx_full
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quiet levels at time zero: transmit empty, nothing received
	initial begin
		port_b_pins = 8'h00;
		capture1_pin = 1'b0;
		capture2_pin = 1'b0;
		serial_tx_empty = 1'b1;
		serial_rx_full = 1'b0;
	end
	// One-cycle high pulse, so exactly one rising edge per call
	task automatic cap_pulse(input int which);
		@(posedge hclk);
		if (which == 1)
			capture1_pin <= 1'b1;
		else
			capture2_pin <= 1'b1;
		@(posedge hclk);
		capture1_pin <= 1'b0;
		capture2_pin <= 1'b0;
	endtask : cap_pulse
	// New pin levels; the mismatch stands until software re-latches
	task automatic set_pins(input logic [7:0] v);
		@(posedge hclk);
		port_b_pins <= v;
	endtask : set_pins
	// Buffer status levels as the serial unit would show them
	task automatic set_serial(input logic tx, input logic rx);
		@(posedge hclk);
		serial_tx_empty <= tx;
		serial_rx_full <= rx;
	endtask : set_serial
endmodule : pirf_periph_model
`default_nettype wire

/* verification/pirf_flag_register_properties.sv */
// Checker of bus timing and flag behaviour at the flag register's ports
`default_nettype none
module pirf_flag_register_properties
	import pirf_pkg::*;
(
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       capture1_pin,
	input wire logic       capture2_pin,
	input wire logic       serial_tx_empty,
	input wire logic       serial_rx_full,
	input wire logic [7:0] peripheral_irq_flags
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Taken transfers; only a write may lower one of flag bits 7 to 2
	wire take = hsel && hready && htrans[1];
	wire wtake = take && hwrite;
	// First cycle after release only primes history, so skip it
	logic up_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			up_reg <= 1'b0;
		else
			up_reg <= 1'b1;
	end
	a_resp_okay: assert property (hresp == HRESP_OKAY)
		else $error("response not okay");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_ready: assert property (wtake |=> hreadyout)
		else $error("write stalled");
	a_cap1_flag: assert property (up_reg && $rose(capture1_pin)
		|-> ##2 peripheral_irq_flags[BIT_CAP1])
		else $error("capture1 flag not set");
	a_cap2_flag: assert property (up_reg && $rose(capture2_pin)
		|-> ##2 peripheral_irq_flags[BIT_CAP2])
		else $error("capture2 flag not set");
	a_tx_live: assert property (up_reg
		|-> peripheral_irq_flags[BIT_TX] == $past(serial_tx_empty))
		else $error("transmit flag not live");
	a_rx_live: assert property (up_reg
		|-> peripheral_irq_flags[BIT_RX] == $past(serial_rx_full))
		else $error("receive flag not live");
	a_clear_by_write: assert property (
		($past(peripheral_irq_flags) & ~peripheral_irq_flags & 8'hFC) != 8'h00
		|-> $past(wtake, 2))
		else $error("flag fell without write");
endmodule : pirf_flag_register_properties
`default_nettype wire
bind pirf_flag_register pirf_flag_register_properties u_chk (.hclk, .hresetn,
	.hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .capture1_pin,
	.capture2_pin, .serial_tx_empty, .serial_rx_full, .peripheral_irq_flags);

/* verification/tb.sv */
// Self-checking bench for the peripheral flag register
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
	$display("Error %s exp %0h got %0h", n, e, s); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pirf_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  port_b_pins, peripheral_irq_flags;
	logic        capture1_pin, capture2_pin, serial_tx_empty, serial_rx_full;
	wire         hready = hreadyout;
	int          n_fail, n_compared;
	pirf_flag_register uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .port_b_pins,
		.capture1_pin, .capture2_pin, .serial_tx_empty, .serial_rx_full,
		.peripheral_irq_flags);
	pirf_periph_model periph (.hclk, .port_b_pins, .capture1_pin,
		.capture2_pin, .serial_tx_empty, .serial_rx_full);
	// 4 ns clock
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	// Ready is judged before the edge, since hreadyout is combinational
	task automatic wait_rdy;
		@(negedge hclk);
		while (hreadyout !== 1'b1) @(negedge hclk);
		@(posedge hclk);
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d);
	endtask : wr
	task automatic rdchk(input string n, input logic [7:0] idx,
		input logic [31:0] e);
		bus(1'b0, idx, 32'h0);
		`CHK(n, e, rd)
	endtask : rdchk
	task automatic t_regs;
		`CHK("reset", 8'h02, peripheral_irq_flags)
		rdchk("bank0", IDX_FLAGS, 32'h0);
		wr(IDX_BANK_SEL, 32'h1);
		rdchk("flags", IDX_FLAGS, 32'h02);
		rdchk("unmapped", 8'h30, 32'h0);
		wr(IDX_FLAGS, 32'hFF);
		rdchk("set", IDX_FLAGS, 32'hFE);
		wr(IDX_FLAGS, 32'h0);
		rdchk("clear", IDX_FLAGS, 32'h02);
		wr(IDX_BANK_SEL, 32'h2);
		wr(IDX_FLAGS, 32'hFC);
		rdchk("bank2", IDX_FLAGS, 32'h0);
		wr(IDX_BANK_SEL, 32'h1);
		rdchk("kept", IDX_FLAGS, 32'h02);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_events;
		periph.set_serial(1'b0, 1'b1);
		repeat (3) @(posedge hclk);
		`CHK("serial", 2'b01, peripheral_irq_flags[1:0])
		periph.set_serial(1'b1, 1'b0);
		periph.cap_pulse(1);
		repeat (4) @(posedge hclk);
		`CHK("serial", 2'b10, peripheral_irq_flags[1:0])
		`CHK("cap", 2'b01, peripheral_irq_flags[3:2])
		periph.cap_pulse(2);
		repeat (4) @(posedge hclk);
		`CHK("cap2", 1'b1, peripheral_irq_flags[3])
		wr(IDX_FLAGS, 32'h0);
		@(negedge hclk);
		`CHK("capclr", 2'b00, peripheral_irq_flags[3:2])
		periph.set_pins(8'h5A);
		repeat (4) @(posedge hclk);
		`CHK("pb", 1'b1, peripheral_irq_flags[7])
		wr(IDX_FLAGS, 32'h0);
		repeat (2) @(posedge hclk);
		`CHK("pbkeep", 1'b1, peripheral_irq_flags[7])
		rdchk("snap", IDX_PORT_B_PINS_SNAP, 32'h5A);
		wr(IDX_FLAGS, 32'h0);
		repeat (3) @(posedge hclk);
		`CHK("pbclr", 1'b0, peripheral_irq_flags[7])
		$display("t_events done");
	endtask : t_events
	// Flag must stay low until the n-count wrap, then be set
	task automatic t_timer(input string nm, input logic [7:0] ctrl,
		input logic [7:0] idx, input logic [15:0] wv, input int n,
		input int b);
		wr(idx, {16'h0, wv});
		wr(IDX_FLAGS, 32'h0);
		wr(IDX_TIMER_CTRL, {24'h0, ctrl});
		repeat (n - 1) @(posedge hclk);
		`CHK(nm, 1'b0, peripheral_irq_flags[b])
		repeat (6) @(posedge hclk);
		`CHK(nm, 1'b1, peripheral_irq_flags[b])
		wr(IDX_TIMER_CTRL, 32'h0);
		$display("timer %s done", nm);
	endtask : t_timer
	// Timer wrapping every cycle races the clear; the set must win
	task automatic t_prio;
		wr(IDX_T2_PERIOD, 32'h0);
		wr(IDX_TIMER_CTRL, 32'h08);
		wr(IDX_FLAGS, 32'h0);
		@(negedge hclk);
		`CHK("prio", 1'b1, peripheral_irq_flags[5])
		@(posedge hclk);
		wr(IDX_TIMER_CTRL, 32'h0);
		$display("t_prio done");
	endtask : t_prio
	// Mid-run reset: timers keep their count when stopped, so later tests
	// start from a known zero count; bank 1 is reselected for flag writes
	task automatic rst;
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK("rst", 8'h02, peripheral_irq_flags)
		wr(IDX_BANK_SEL, 32'h1);
	endtask : rst
	// Watchdog sized well above the long third-timer overflow test
	initial begin
		repeat (90000) @(posedge hclk);
		n_fail++;
		close_out();
	end
	// Reset for four cycles, then the tests
	initial begin
		n_fail = 0;
		n_compared = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_events();
		t_timer("t1", 8'h04, IDX_T1_PERIOD, 16'd6, 7, BIT_T1);
		t_timer("t2", 8'h08, IDX_T2_PERIOD, 16'd9, 10, BIT_T2);
		t_timer("t3", 8'h10, IDX_T3_PERIOD, 16'd12, 13, BIT_T3);
		rst();
		wr(IDX_T1_PERIOD, 32'h0);
		t_timer("wide", 8'h05, IDX_T2_PERIOD, 16'd7, 8, BIT_T1);
		rst();
		t_timer("ovf", 8'h12, IDX_T3_PERIOD, 16'd12, 65536, BIT_T3);
		rst();
		t_prio();
		close_out();
	end
endmodule : tb
`default_nettype wire
